// file: logic/psr_defs.vh
// constants for the power sequencing and status register block
// assumes inclusion by the single design file; definitions only
`ifndef PSR_DEFS_VH
`define PSR_DEFS_VH
// command codes
`define PSR_CMD_GOOD_THR     8'h5e
`define PSR_CMD_TURN_ON_DELAY    8'h60
`define PSR_CMD_TON_RAMP     8'h61
`define PSR_CMD_TURN_OFF_DELAY   8'h64
`define PSR_CMD_TOFF_RAMP    8'h65
`define PSR_CMD_SUMMARY      8'h78
`define PSR_CMD_SUMMARY_WORD 8'h79
`define PSR_CMD_VOUT_STATUS  8'h7a
// reset values
`define PSR_SEQ_RESET        16'hca80
`define PSR_STATUS_RESET     8'h00
// summary bit positions
`define PSR_SB_BUSY          7
`define PSR_SB_OFF           6
`define PSR_SB_OVF           5
`define PSR_SB_OCF           4
`define PSR_SB_VINUV         3
`define PSR_SB_TEMP          2
`define PSR_SB_CML           1
`define PSR_SB_OTHER         0
// millisecond tick: 1 ms at 125 MHz
`define PSR_MS_LAST          17'd124999
// sequencing ranges in ms
`define PSR_DELAY_MAX_MS     10'd500
`define PSR_RAMP_MAX_MS      10'd200
`endif

// file: logic/psr_power_seq_status_regs.v
// power sequencing timers, output-good threshold and fault status registers
// assumes a serial bus front end that delivers decoded command strobes on sys_clk
// and fault event pulses from the analog monitors, already on sys_clk
//
// What this block does
// RL1 - output good rises above threshold, falls only below undervoltage limit
// RL2 - good threshold is read/write word, resets to 0.9 times strapped setpoint
// RL3 - wait turn-on delay, 0 to 500 ms, after enable before ramping up
// RL4 - ramp output up over turn-on ramp time, 0 to 200 ms
// RL5 - wait turn-off delay, 0 to 500 ms, after disable before ramping down
// RL6 - ramp output down over turn-off ramp time, 0 to 200 ms
// RL7 - four sequencing words, linear-11 milliseconds, reset to 5 ms encoding
// RL8 - summary byte read returns critical faults, resets to zero
// RL9 - bit 7 flags busy fault
// RL10 - bit 6 set whenever output power is not delivered
// RL11 - bits 5,4,3 flag overvoltage, overcurrent, input undervoltage
// RL12 - bit 2 temperature, bit 1 comm/memory/logic, bit 0 fan or unknown event
// RL13 - status word low byte is the summary byte register itself
// RL14 - word bits 15..12 flag vout, iout, input, maker specific
// RL15 - bit 11 power good negated, 10 fans, 9 other status, 8 unknown
// RL16 - vout status bits 7..4 ov fault, ov warn, uv warn, uv fault
// RL17 - vout bit 3 set on setpoint request above ceiling
// RL18 - bits 2,1 turn-on/off timeout, bit 0 tracking error
// RL19 - fault bits stick until the clear-faults command
// RL20 - intervals timed by millisecond tick, restart on each enable change
`timescale 1ns/10ps
`include "psr_defs.vh"

module psr_power_seq_status_regs (
  input  wire        sys_clk,
  input  wire        rst_b,
  input  wire        cmd_write,
  input  wire        cmd_read,
  input  wire [7:0]  cmd_code,
  input  wire [15:0] cmd_wdata,
  output reg  [15:0] cmd_rdata,
  output reg         cmd_hit,
  input  wire        clear_faults,
  input  wire [15:0] strap_good_default,
  input  wire        enable_pin,
  input  wire [15:0] output_voltage,
  input  wire [15:0] output_undervoltage_limit,
  input  wire        busy_fault,
  input  wire        output_overvoltage_fault,
  input  wire        output_overvoltage_warning,
  input  wire        output_undervoltage_warning,
  input  wire        output_undervoltage_fault,
  input  wire        output_overcurrent_fault,
  input  wire        iout_other_event,
  input  wire        input_undervoltage_fault,
  input  wire        input_other_event,
  input  wire        temperature_event,
  input  wire        comm_memory_logic_fault,
  input  wire        mfg_event,
  input  wire        fan_event,
  input  wire        other_status_set,
  input  wire        unknown_event,
  input  wire        output_voltage_ceiling_hit,
  input  wire        turn_on_timeout_fault,
  input  wire        turn_off_timeout_fault,
  input  wire        output_tracking_error,
  output reg         output_good,
  output reg         ramp_up,
  output reg         ramp_down,
  output reg         output_on
);

  // ----------------------------------------------------------------
  // enable pin synchroniser
  // ----------------------------------------------------------------
  reg en_meta;
  reg en_sync;
  reg en_prev;

  // first stage feeds only the second stage
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      en_meta <= 1'b0;
      en_sync <= 1'b0;
      en_prev <= 1'b0;
    end else begin
      en_meta <= enable_pin;
      en_sync <= en_meta;
      en_prev <= en_sync;
    end
  end

  // ----------------------------------------------------------------
  // configuration words
  // ----------------------------------------------------------------
  reg [15:0] output_good_threshold;
  reg [15:0] turn_on_delay;
  reg [15:0] turn_on_ramp_time;
  reg [15:0] turn_off_delay;
  reg [15:0] turn_off_ramp_time;
  reg        thr_loaded;

  // the threshold takes the strap value after reset release, since an async
  // reset may only load constants
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      output_good_threshold <= 16'h0000;
      thr_loaded            <= 1'b0;
      turn_on_delay         <= `PSR_SEQ_RESET;  // see RL7
      turn_on_ramp_time     <= `PSR_SEQ_RESET;
      turn_off_delay        <= `PSR_SEQ_RESET;
      turn_off_ramp_time    <= `PSR_SEQ_RESET;
    end else begin
      thr_loaded <= 1'b1;
      if (!thr_loaded)
        output_good_threshold <= strap_good_default;  // see RL2
      else if (cmd_write && cmd_code == `PSR_CMD_GOOD_THR)
        output_good_threshold <= cmd_wdata;  // see RL2
      if (cmd_write && cmd_code == `PSR_CMD_TURN_ON_DELAY)
        turn_on_delay <= cmd_wdata;  // see RL7
      if (cmd_write && cmd_code == `PSR_CMD_TON_RAMP)
        turn_on_ramp_time <= cmd_wdata;
      if (cmd_write && cmd_code == `PSR_CMD_TURN_OFF_DELAY)
        turn_off_delay <= cmd_wdata;
      if (cmd_write && cmd_code == `PSR_CMD_TOFF_RAMP)
        turn_off_ramp_time <= cmd_wdata;
    end
  end

  // ----------------------------------------------------------------
  // linear-11 to whole milliseconds
  // ----------------------------------------------------------------
  // mantissa is signed 11 bits, exponent signed 5 bits; negatives clamp
  // to zero and the result saturates at the allowed range
  function [9:0] psr_l11_ms;
    input [15:0] val;
    input [9:0]  limit;
    reg   [4:0]  ex;
    reg   [41:0] wide;
    begin
      ex   = val[15:11];
      wide = {31'd0, val[10:0]};
      if (val[10])
        psr_l11_ms = 10'd0;
      else begin
        if (ex[4])
          wide = wide >> (~ex + 5'd1);
        else
          wide = wide << ex;
        psr_l11_ms = (wide > {32'd0, limit}) ? limit : wide[9:0];
      end
    end
  endfunction

  wire [9:0] on_delay_ms  = psr_l11_ms(turn_on_delay, `PSR_DELAY_MAX_MS);
  wire [9:0] on_ramp_ms   = psr_l11_ms(turn_on_ramp_time, `PSR_RAMP_MAX_MS);
  wire [9:0] off_delay_ms = psr_l11_ms(turn_off_delay, `PSR_DELAY_MAX_MS);
  wire [9:0] off_ramp_ms  = psr_l11_ms(turn_off_ramp_time, `PSR_RAMP_MAX_MS);

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  localparam [4:0] ST_OFF   = 5'b00001;
  localparam [4:0] ST_ONDLY = 5'b00010;
  localparam [4:0] ST_RISE  = 5'b00100;
  localparam [4:0] ST_ON    = 5'b01000;
  localparam [4:0] ST_FALL  = 5'b10000;

  reg [4:0]  state;
  reg [4:0]  next_state;
  reg [16:0] tick_cnt;
  reg [9:0]  ms_cnt;
  reg        off_wait;
  reg        next_off_wait;
  wire       en_rise = en_sync & ~en_prev;
  wire       en_fall = ~en_sync & en_prev;
  wire       ms_tick = (tick_cnt == `PSR_MS_LAST);
  reg  [9:0] target;
  reg        restart;

  // interval target and next state
  always @* begin
    next_state = state;
    restart    = 1'b0;
    target     = 10'd0;
    case (state)
      ST_ONDLY: target = on_delay_ms;
      ST_RISE:  target = on_ramp_ms;
      ST_FALL:  target = off_wait ? off_delay_ms : off_ramp_ms;
      default:  target = 10'd0;
    endcase
    if (en_rise && state != ST_ON) begin
      next_state = ST_ONDLY;  // see RL3
      restart    = 1'b1;      // see RL20
    end else if (en_fall && state != ST_OFF) begin
      next_state = ST_FALL;   // see RL5
      restart    = 1'b1;      // see RL20
    end else if (ms_cnt >= target) begin
      case (state)
        ST_ONDLY: begin
          next_state = ST_RISE;  // see RL4
          restart    = 1'b1;
        end
        ST_RISE:  next_state = ST_ON;
        ST_FALL:  begin
          restart = 1'b1;
          if (!off_wait)
            next_state = ST_OFF;  // see RL6
        end
        default:  next_state = state;
      endcase
    end
  end

  // pending turn-off delay flag; computed ahead so the fall strobe lines up with the state
  always @* begin
    next_off_wait = off_wait;
    if (en_fall && state != ST_OFF)
      next_off_wait = 1'b1;  // see RL5
    if (state == ST_FALL && off_wait && ms_cnt >= off_delay_ms && !en_fall)
      next_off_wait = 1'b0;
    if (en_rise)
      next_off_wait = 1'b0;
  end

  // millisecond tick and interval counter
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state    <= ST_OFF;
      tick_cnt <= 17'd0;
      ms_cnt   <= 10'd0;
      off_wait <= 1'b0;
    end else begin
      state <= next_state;
      if (restart) begin
        tick_cnt <= 17'd0;
        ms_cnt   <= 10'd0;
      end else begin
        tick_cnt <= ms_tick ? 17'd0 : tick_cnt + 17'd1;  // see RL20
        if (ms_tick && ms_cnt != 10'h3ff)
          ms_cnt <= ms_cnt + 10'd1;
      end
      off_wait <= next_off_wait;  // see RL5
    end
  end

  // sequencing outputs registered from the next state
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ramp_up   <= 1'b0;
      ramp_down <= 1'b0;
      output_on <= 1'b0;
    end else begin
      ramp_up   <= (next_state == ST_RISE);  // see RL4
      ramp_down <= (next_state == ST_FALL) && !next_off_wait;  // see RL6
      output_on <= (next_state == ST_RISE) || (next_state == ST_ON) || (next_state == ST_FALL);
    end
  end

  // ----------------------------------------------------------------
  // output good hysteresis
  // ----------------------------------------------------------------
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b)
      output_good <= 1'b0;
    else if (output_voltage > output_good_threshold)
      output_good <= 1'b1;  // see RL1
    else if (output_voltage < output_undervoltage_limit)
      output_good <= 1'b0;  // see RL1
  end

  // ----------------------------------------------------------------
  // sticky status; set beats clear in the same cycle
  // ----------------------------------------------------------------
  reg [7:0] fault_summary_byte;  // low byte of the word, one register, see RL13
  reg [7:0] summary_high;
  reg [7:0] output_voltage_status;
  wire [7:0] sum_ev = {busy_fault, 1'b0, output_overvoltage_fault, output_overcurrent_fault,
                       input_undervoltage_fault, temperature_event, comm_memory_logic_fault,
                       unknown_event | fan_event};  // see RL9 see RL11 see RL12
  wire [7:0] vout_ev = {output_overvoltage_fault, output_overvoltage_warning, output_undervoltage_warning,
                        output_undervoltage_fault, output_voltage_ceiling_hit, turn_on_timeout_fault,
                        turn_off_timeout_fault, output_tracking_error};  // see RL16 see RL17 see RL18
  wire       vout_any = |vout_ev;
  wire [7:0] hi_ev = {vout_any, output_overcurrent_fault | iout_other_event,
                      input_undervoltage_fault | input_other_event, mfg_event,
                      1'b0, fan_event, other_status_set, unknown_event};  // see RL14 see RL15

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_sticky
      always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
          fault_summary_byte[gi]    <= 1'b0;  // see RL8
          summary_high[gi]          <= 1'b0;
          output_voltage_status[gi] <= 1'b0;
        end else begin
          fault_summary_byte[gi]    <= sum_ev[gi] | (fault_summary_byte[gi] & ~clear_faults);  // see RL19
          summary_high[gi]          <= hi_ev[gi] | (summary_high[gi] & ~clear_faults);
          output_voltage_status[gi] <= vout_ev[gi] | (output_voltage_status[gi] & ~clear_faults);
        end
      end
    end
  endgenerate

  // live bits: off and power-good-negated track present state
  wire [7:0] sum_live  = {fault_summary_byte[7], ~output_on, fault_summary_byte[5:0]};  // see RL10
  wire [7:0] high_live = {summary_high[7:4], ~output_good, summary_high[2:0]};          // see RL15

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cmd_rdata <= 16'h0000;
      cmd_hit   <= 1'b0;
    end else begin
      cmd_hit <= cmd_read || cmd_write;
      if (cmd_read) begin
        case (cmd_code)
          `PSR_CMD_GOOD_THR:     cmd_rdata <= output_good_threshold;
          `PSR_CMD_TURN_ON_DELAY:    cmd_rdata <= turn_on_delay;
          `PSR_CMD_TON_RAMP:     cmd_rdata <= turn_on_ramp_time;
          `PSR_CMD_TURN_OFF_DELAY:   cmd_rdata <= turn_off_delay;
          `PSR_CMD_TOFF_RAMP:    cmd_rdata <= turn_off_ramp_time;
          `PSR_CMD_SUMMARY:      cmd_rdata <= {8'h00, sum_live};  // see RL8
          `PSR_CMD_SUMMARY_WORD: cmd_rdata <= {high_live, sum_live};  // see RL13
          `PSR_CMD_VOUT_STATUS:  cmd_rdata <= {8'h00, output_voltage_status};  // see RL16
          default:               cmd_rdata <= 16'h0000;
        endcase
      end
    end
  end

endmodule

// file: verification/psr_checker.sv
// checker for the sequencing and status register block
// assumes a bind onto the block top, one clock domain
`timescale 1ns/10ps
module psr_checker (
  input wire        sys_clk,
  input wire        rst_b,
  input wire        cmd_write,
  input wire        cmd_read,
  input wire [7:0]  cmd_code,
  input wire [15:0] cmd_wdata,
  input wire [15:0] cmd_rdata,
  input wire        cmd_hit,
  input wire        clear_faults,
  input wire [15:0] output_voltage,
  input wire [15:0] output_undervoltage_limit,
  input wire        output_good,
  input wire        ramp_up,
  input wire        ramp_down
);
  // ----------
  // properties
  // ----------
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  AST_HIT: assert property ((cmd_read || cmd_write) |=> cmd_hit)
    else $error("no answer after request");
  AST_NO_HIT: assert property (!(cmd_read || cmd_write) |=> !cmd_hit)
    else $error("answer without request");
  AST_HOLD: assert property (!cmd_read |=> $stable(cmd_rdata))
    else $error("read data moved without a read");
  // threshold word written then read back two cycles on
  AST_THR_RW: assert property ((cmd_write && cmd_code == 8'h5e) ##1 !cmd_write ##1
    (cmd_read && cmd_code == 8'h5e) |=> cmd_rdata == $past(cmd_wdata, 3))
    else $error("threshold word lost");
  AST_GOOD_BIT: assert property (cmd_read && cmd_code == 8'h79 |=>
    cmd_rdata[11] == !$past(output_good)) else $error("good bit wrong");
  // good may only drop once the output is under the undervoltage limit
  AST_GOOD_HOLD: assert property (output_good && output_voltage >= output_undervoltage_limit
    |=> output_good) else $error("good dropped above limit");
  AST_RAMPS: assert property (!(ramp_up && ramp_down))
    else $error("both ramps active");
  // without a clear between two reads of the output-voltage status byte, none of its bits may vanish
  AST_STICKY: assert property ((cmd_read && cmd_code == 8'h7a && !clear_faults)
    ##1 !clear_faults ##1 (cmd_read && cmd_code == 8'h7a) |=>
    ((cmd_rdata & $past(cmd_rdata, 2) & 16'h00ff) == ($past(cmd_rdata, 2) & 16'h00ff)))
    else $error("fault bit vanished");
  cover property ($fell(output_good));
  cover property (clear_faults);
  cover property (cmd_write && cmd_code == 8'h5e);
endmodule

// file: verification/psr_host_model.sv
// bus host model issuing command reads and writes
// assumes inputs sampled on the rising edge, drives on the falling edge
`timescale 1ns/10ps
module psr_host_model (
  input  wire        sys_clk,
  output reg         cmd_write,
  output reg         cmd_read,
  output reg  [7:0]  cmd_code,
  output reg  [15:0] cmd_wdata,
  input  wire [15:0] cmd_rdata,
  input  wire        cmd_hit
);
  initial begin
    cmd_write = 1'b0;
    cmd_read  = 1'b0;
    cmd_code  = 8'hff;
    cmd_wdata = 16'h0000;
  end
  // released lines show the inverse so stale values cannot pass
  task wr(input [7:0] c, input [15:0] d);
    begin
      @(negedge sys_clk);
      cmd_write = 1'b1;
      cmd_code  = c;
      cmd_wdata = d;
      @(negedge sys_clk);
      cmd_write = 1'b0;
      cmd_code  = ~c;
      cmd_wdata = ~d;
    end
  endtask
  // a missing answer returns unknown so the compare fails
  task rd(input [7:0] c, output [15:0] d);
    begin
      @(negedge sys_clk);
      cmd_read = 1'b1;
      cmd_code = c;
      @(negedge sys_clk);
      d = cmd_hit ? cmd_rdata : 16'hxxxx;
      cmd_read = 1'b0;
      cmd_code = ~c;
    end
  endtask
endmodule

// file: verification/testbench.sv
// self-checking bench for the sequencing and status registers
// assumes the host model and checker files compiled first
`timescale 1ns/10ps
module testbench;
  reg         sys_clk;
  reg         rst_b;
  reg         clear_faults;
  reg         enable_pin;
  reg         oth;
  reg  [17:0] ev;
  reg  [15:0] vout;
  reg  [15:0] rdat;
  reg         up_seen = 1'b0;
  reg         down_seen = 1'b0;
  wire        cmd_write, cmd_read, cmd_hit, output_good, output_on, ramp_up, ramp_down;
  wire [7:0]  cmd_code;
  wire [15:0] cmd_wdata, cmd_rdata;
  integer     error_cnt, checked, i, n;
  localparam [31:0] SEQ = {8'h60, 8'h61, 8'h64, 8'h65};
  // per event: summary word, output-voltage status byte
  localparam [24*18-1:0] EXP = {24'h008000, 24'h802080, 24'h800040, 24'h800020, 24'h800010,
    24'h401000, 24'h400000, 24'h200800, 24'h200000, 24'h000400, 24'h000200, 24'h100000,
    24'h040100, 24'h010100, 24'h800008, 24'h800004, 24'h800002, 24'h800001};
  psr_host_model h (.sys_clk, .cmd_write, .cmd_read, .cmd_code, .cmd_wdata, .cmd_rdata, .cmd_hit);
  psr_power_seq_status_regs DUT (.sys_clk, .rst_b, .cmd_write, .cmd_read, .cmd_code,
    .cmd_wdata, .cmd_rdata, .cmd_hit, .clear_faults, .strap_good_default(16'h0e66),
    .enable_pin, .output_voltage(vout), .output_undervoltage_limit(16'h1000),
    .busy_fault(ev[0]), .output_overvoltage_fault(ev[1]), .output_overvoltage_warning(ev[2]),
    .output_undervoltage_warning(ev[3]), .output_undervoltage_fault(ev[4]),
    .output_overcurrent_fault(ev[5]), .iout_other_event(ev[6]), .input_undervoltage_fault(ev[7]),
    .input_other_event(ev[8]), .temperature_event(ev[9]), .comm_memory_logic_fault(ev[10]),
    .mfg_event(ev[11]), .fan_event(ev[12]), .other_status_set(oth), .unknown_event(ev[13]),
    .output_voltage_ceiling_hit(ev[14]), .turn_on_timeout_fault(ev[15]),
    .turn_off_timeout_fault(ev[16]), .output_tracking_error(ev[17]), .output_good,
    .ramp_up, .ramp_down, .output_on);
  task cmp(input [15:0] g, input [15:0] e);
    begin
      checked = checked + 1;
      if (g !== e) begin
        error_cnt = error_cnt + 1;
        $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
    end
  endtask
  task print_verdict;
    begin
      if (error_cnt == 0 && checked > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  // ----------
  // tests
  // ----------
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // ramp strobes may last one cycle only, so remember that each showed up
  always @(posedge sys_clk) begin
    if (ramp_up)
      up_seen <= 1'b1;
    if (ramp_down)
      down_seen <= 1'b1;
  end
  // one run takes well under 20 us; a hang is cut at 200 us
  initial begin
    #200000;
    error_cnt = error_cnt + 1;
    print_verdict;
  end
  initial begin
    {rst_b, clear_faults, enable_pin, oth, ev, vout} = 0;
    error_cnt = 0;
    checked = 0;
    repeat (16) @(negedge sys_clk);
    rst_b = 1'b1;
    for (i = 0; i < 4; i = i + 1) begin
      h.rd(SEQ[i*8 +: 8], rdat);
      cmp(rdat, 16'hca80);
    end
    h.rd(8'h5e, rdat);
    cmp(rdat, 16'h0e66);
    h.wr(8'h79, 16'hffff);
    h.rd(8'h79, rdat);
    cmp(rdat, 16'h0840);
    h.rd(8'h00, rdat);
    cmp(rdat, 16'h0000);
    h.wr(8'h5e, 16'h1800);
    h.rd(8'h5e, rdat);
    cmp(rdat, 16'h1800);
    // each event is a one-cycle pulse, so the bits must stick
    for (i = 0; i < 18; i = i + 1) begin
      @(negedge sys_clk);
      ev = 18'h1 << i;
      @(negedge sys_clk);
      ev = 18'h0;
      h.rd(8'h7a, rdat);
      h.rd(8'h7a, rdat);
      cmp({8'h00, rdat[7:0]}, {8'h00, EXP[(17-i)*24 +: 8]});
      h.rd(8'h79, rdat);
      cmp(rdat, EXP[(17-i)*24+8 +: 16] | 16'h0840);
      h.rd(8'h78, rdat);
      cmp({8'h00, rdat[7:0]}, {8'h00, EXP[(17-i)*24+8 +: 8] | 8'h40});
      clear_faults = 1'b1;
      @(negedge sys_clk);
      clear_faults = 1'b0;
      h.rd(8'h79, rdat);
      cmp(rdat, 16'h0840);
    end
    oth = 1'b1;
    h.rd(8'h79, rdat);
    cmp(rdat, 16'h0a40);
    oth = 1'b0;
    clear_faults = 1'b1;
    @(negedge sys_clk);
    clear_faults = 1'b0;
    for (i = 0; i < 4; i = i + 1) begin
      h.wr(SEQ[i*8 +: 8], 16'h0000);
      h.rd(SEQ[i*8 +: 8], rdat);
      cmp(rdat, 16'h0000);
    end
    // zero delays and ramps keep the run short
    vout = 16'h2000;
    enable_pin = 1'b1;
    for (n = 0; n < 60 && output_on !== 1'b1; n = n + 1) @(negedge sys_clk);
    cmp({15'h0, output_on}, 16'h0001);
    h.rd(8'h79, rdat);
    cmp(rdat, 16'h0000);
    cmp({15'h0, up_seen}, 16'h0001);
    cmp({15'h0, down_seen}, 16'h0000);
    vout = 16'h1400;
    repeat (4) @(negedge sys_clk);
    cmp({15'h0, output_good}, 16'h0001);
    vout = 16'h0800;
    repeat (4) @(negedge sys_clk);
    cmp({15'h0, output_good}, 16'h0000);
    enable_pin = 1'b0;
    for (n = 0; n < 60 && output_on !== 1'b0; n = n + 1) @(negedge sys_clk);
    cmp({15'h0, output_on}, 16'h0000);
    h.rd(8'h79, rdat);
    cmp(rdat, 16'h0840);
    cmp({15'h0, down_seen}, 16'h0001);
    print_verdict;
  end
endmodule
bind psr_power_seq_status_regs psr_checker chk (.sys_clk, .rst_b, .cmd_write, .cmd_read,
  .cmd_code, .cmd_wdata, .cmd_rdata, .cmd_hit, .clear_faults, .output_voltage,
  .output_undervoltage_limit, .output_good, .ramp_up, .ramp_down);
